// ===== hw/word_cpu_defines.svh
`ifndef WORD_CPU_DEFINES_SVH
`define WORD_CPU_DEFINES_SVH

// Word and field geometry, bit 0 is the most significant bit of the word
`define WORD_W        24
`define ADDR_W        14
`define OPCODE_W      6
`define ICODE_W       7
`define MEM_W         25
// Field positions as LSB-based vector indices for a [23:0] word
`define POS_SPARE     23
`define POS_OFFSET    22
`define ICODE_HI      21
`define ICODE_LO      15
`define OPCODE_HI     20
`define OPCODE_LO     15
`define POS_DEFER     14
`define ADDR_HI       13
`define ADDR_LO       0
`define PREFIX_HI     23
`define PREFIX_LO     21
// Highest address per installed size
`define LIMIT_2K      14'h07ff
`define LIMIT_4K      14'h0fff
`define LIMIT_8K      14'h1fff
`define LIMIT_16K     14'h3fff
`define SIZE_2K       2'h0
`define SIZE_4K       2'h1
`define SIZE_8K       2'h2
`define SIZE_16K      2'h3
// Reset values
`define WORD_RST      24'h000000
`define ADDR_RST      14'h0000
`define OPCODE_RST    6'h00
`define MEM_RST       25'h0000000

`endif

// ===== hw/word_cpu_pkg.sv
`include "word_cpu_defines.svh"

package word_cpu_pkg;

  // Decoded instruction fields
  typedef struct packed {
    logic                 offset_flag;
    logic [`ICODE_W-1:0]  icode;
    logic                 deferred_flag;
    logic [`ADDR_W-1:0]   address;
    logic [2:0]           flag_prefix;
    logic                 progop;
  } decode_t;

  // Memory port request
  typedef struct packed {
    logic                 rd;
    logic                 wr;
    logic [`ADDR_W-1:0]   addr;
    logic [`MEM_W-1:0]    wdata;
  } mem_req_t;

  // Programmer-visible register set
  typedef struct packed {
    logic [`WORD_W-1:0]   sum_register;
    logic [`WORD_W-1:0]   low_extension;
    logic [`WORD_W-1:0]   offset_word;
    logic [`ADDR_W-1:0]   instruction_locator;
  } visible_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_DEFER,
    ST_OPERAND,
    ST_DONE,
    ST_HALT
  } cpu_state_t;

endpackage : word_cpu_pkg

// ===== hw/word_cpu_register_and_decode.sv
`timescale 1ns/1ps
`default_nettype none

module word_cpu_register_and_decode
  import word_cpu_pkg::*;
(
  input  wire logic                     clk_sys_in,       // 100 MHz clock
  input  wire logic                     rst_in,           // Sync reset, high
  input  wire logic                     start_in,         // Run one instruction
  input  wire logic [1:0]               mem_size_in,      // Installed memory size
  input  wire logic                     power_ok_in,      // Power adequate
  input  wire logic                     parity_halt_in,   // Panel parity halt
  input  wire logic                     store_in,         // Operand is a store
  input  wire logic                     redirect_in,      // Branch/skip taken
  input  wire logic [`ADDR_W-1:0]       redirect_addr_in, // Branch target
  input  wire logic                     load_sum_in,      // Load sum from operand
  input  wire logic                     load_low_in,      // Load low ext
  input  wire logic                     load_offset_in,   // Load offset word
  input  wire logic [`WORD_W-1:0]       store_data_in,    // Word to store
  input  wire logic [`MEM_W-1:0]        mem_rdata_in,     // Memory read word
  output var word_cpu_pkg::mem_req_t    mem_req_out,      // Memory request
  output var word_cpu_pkg::visible_t    visible_out,      // Visible registers
  output var word_cpu_pkg::decode_t     decode_out,       // Decoded fields
  output logic [`WORD_W-1:0]            working_word_out, // Working register
  output logic [`OPCODE_W-1:0]          verb_out,         // Verb latch
  output logic [`ADDR_W-1:0]            effective_out,    // Effective address
  output logic                          busy_out,         // Instruction running
  output logic                          done_out,         // Instruction finished
  output logic                          halted_out,       // Processor halted
  output logic                          parity_err_out,   // Sticky parity error
  output logic                          power_fail_out    // Sticky power loss
);
  import word_cpu_pkg::*;

  // ==========================================================
  // Registers
  cpu_state_t           state;
  logic [`WORD_W-1:0]   sum_register;
  logic [`WORD_W-1:0]   low_extension;
  logic [`WORD_W-1:0]   offset_word;
  logic [`ADDR_W-1:0]   instruction_locator;
  logic [`ADDR_W-1:0]   location_latch;
  logic [`WORD_W-1:0]   working_word;
  logic [`OPCODE_W-1:0] verb_latch;
  logic [`MEM_W-1:0]    readback_word;
  logic                 mem_rd;
  logic                 mem_wr;
  logic                 is_store;
  logic                 parity_err;
  logic                 power_fail;
  logic                 done;

  // ==========================================================
  // Address limit and absent-memory detection
  logic [`ADDR_W-1:0]   addr_limit;
  logic                 addr_present;
  logic [`WORD_W-1:0]   read_word;
  logic                 read_parity_bad;
  logic [`ADDR_W-1:0]   indexed_addr;
  logic [`ADDR_W-1:0]   next_locator;

  always_comb begin
    case (mem_size_in)
      `SIZE_2K: addr_limit = `LIMIT_2K;
      `SIZE_4K: addr_limit = `LIMIT_4K;
      `SIZE_8K: addr_limit = `LIMIT_8K;
      default:  addr_limit = `LIMIT_16K;
    endcase
  end

  assign addr_present = (location_latch <= addr_limit);
  // Absent locations read as zero with good parity
  assign read_word = addr_present ? mem_rdata_in[`WORD_W-1:0] : `WORD_RST;
  // Even parity across the 25 bits
  assign read_parity_bad = addr_present & (^mem_rdata_in);

  // Bit 1 set: add offset word bits 10-23, carry out dropped
  assign indexed_addr = working_word[`POS_OFFSET]
                      ? working_word[`ADDR_HI:`ADDR_LO] + offset_word[`ADDR_HI:`ADDR_LO]
                      : working_word[`ADDR_HI:`ADDR_LO];
  // 14-bit add wraps 37777 to 00000
  assign next_locator = instruction_locator + 14'h0001;

  // ==========================================================
  // Control sequencer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:    if (start_in) state <= ST_FETCH;
        ST_FETCH:   begin
          if (!power_ok_in) state <= ST_HALT;
          else state <= ST_DECODE;
        end
        ST_DECODE:  begin
          if (read_parity_bad && parity_halt_in) state <= ST_HALT;
          else if (working_word_deferred(read_word)) state <= ST_DEFER;
          else state <= ST_OPERAND;
        end
        ST_DEFER:   begin
          if (!power_ok_in) state <= ST_HALT;
          else state <= ST_DECODE;
        end
        ST_OPERAND: begin
          if (!power_ok_in) state <= ST_HALT;
          else state <= ST_DONE;
        end
        ST_DONE:    begin
          if (read_parity_bad && parity_halt_in) state <= ST_HALT;
          else state <= ST_IDLE;
        end
        ST_HALT:    state <= ST_HALT;
        default:    state <= ST_IDLE;
      endcase
    end
  end

  function automatic logic working_word_deferred(input logic [`WORD_W-1:0] w);
    working_word_deferred = w[`POS_DEFER];
  endfunction : working_word_deferred

  // Opcode captured at first decode, held through execution
  logic first_decode;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      first_decode <= 1'b0;
    end else if (state == ST_FETCH) begin
      first_decode <= 1'b1;
    end else if (state == ST_DECODE) begin
      first_decode <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      verb_latch <= `OPCODE_RST;
    end else if (state == ST_DECODE && first_decode) begin
      verb_latch <= read_word[`OPCODE_HI:`OPCODE_LO];
    end
  end

  // ==========================================================
  // Location latch drives every memory access
  // Moves on only after the write-back, so each word returns to its own location
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      location_latch <= `ADDR_RST;
    end else begin
      case (state)
        ST_IDLE:    location_latch <= instruction_locator;
        ST_DEFER,
        ST_OPERAND: location_latch <= indexed_addr;
        default:    location_latch <= location_latch;
      endcase
    end
  end

  // ==========================================================
  // Working word and readback word
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      working_word <= `WORD_RST;
    end else if (state == ST_DECODE || state == ST_DONE) begin
      working_word <= read_word;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      readback_word <= `MEM_RST;
    end else if (state == ST_DECODE || state == ST_DONE) begin
      if (is_store) begin
        readback_word <= {^store_data_in, store_data_in};
      end else begin
        readback_word <= {^read_word, read_word};
      end
    end
  end

  // Memory strobes: read in access states, write-back follows each read of a present address
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mem_rd   <= 1'b0;
      mem_wr   <= 1'b0;
      is_store <= 1'b0;
    end else begin
      mem_rd <= power_ok_in &&
                (state == ST_FETCH || state == ST_DEFER || state == ST_OPERAND);
      // Write-back suppressed for absent addresses
      mem_wr <= (state == ST_DECODE || state == ST_DONE) && addr_present;
      if (state == ST_IDLE) is_store <= 1'b0;
      else if (state == ST_OPERAND) is_store <= store_in;
    end
  end

  // ==========================================================
  // Visible registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sum_register  <= `WORD_RST;
      low_extension <= `WORD_RST;
      offset_word   <= `WORD_RST;
    end else if (state == ST_DONE && !is_store) begin
      if (load_sum_in)    sum_register  <= read_word;
      if (load_low_in)    low_extension <= read_word;
      if (load_offset_in) offset_word   <= read_word;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      instruction_locator <= `ADDR_RST;
    end else if (state == ST_DONE) begin
      instruction_locator <= redirect_in ? redirect_addr_in : next_locator;
    end
  end

  // ==========================================================
  // Status
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      parity_err <= 1'b0;
      power_fail <= 1'b0;
      done       <= 1'b0;
    end else begin
      if ((state == ST_DECODE || state == ST_DONE) && read_parity_bad) parity_err <= 1'b1;
      if ((state == ST_FETCH || state == ST_DEFER || state == ST_OPERAND) && !power_ok_in)
        power_fail <= 1'b1;
      done <= (state == ST_DONE);
    end
  end

  // ==========================================================
  // Outputs; decode view of the working word, bit 0 ignored
  always_comb begin
    decode_out.offset_flag   = working_word[`POS_OFFSET];
    decode_out.icode         = working_word[`ICODE_HI:`ICODE_LO];
    decode_out.deferred_flag = working_word[`POS_DEFER];
    decode_out.address       = working_word[`ADDR_HI:`ADDR_LO];
    decode_out.flag_prefix   = {1'b0, working_word[`POS_OFFSET], working_word[`ICODE_HI]};
    decode_out.progop        = working_word[`ICODE_HI];
  end

  assign mem_req_out.rd    = mem_rd;
  assign mem_req_out.wr    = mem_wr;
  assign mem_req_out.addr  = location_latch;
  assign mem_req_out.wdata = readback_word;
  assign visible_out.sum_register        = sum_register;
  assign visible_out.low_extension       = low_extension;
  assign visible_out.offset_word         = offset_word;
  assign visible_out.instruction_locator = instruction_locator;
  assign working_word_out = working_word;
  assign verb_out         = verb_latch;
  assign effective_out    = indexed_addr;
  assign busy_out         = (state != ST_IDLE) && (state != ST_HALT);
  assign done_out         = done;
  assign halted_out       = (state == ST_HALT);
  assign parity_err_out   = parity_err;
  assign power_fail_out   = power_fail;

  // ==========================================================
  // Assertions
  property p_wrap;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == ST_DONE && !redirect_in && instruction_locator == `LIMIT_16K)
      |=> instruction_locator == `ADDR_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("locator did not wrap");

  property p_incr;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == ST_DONE && !redirect_in) |=> instruction_locator == $past(instruction_locator) + 14'h0001;
  endproperty
  a_incr: assert property (p_incr) else $error("locator not incremented");

  property p_power;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == ST_FETCH && !power_ok_in) |=> halted_out ##1 halted_out;
  endproperty
  a_power: assert property (p_power) else $error("no halt on power loss");

  property p_nowr_absent;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == ST_DONE && !addr_present) |=> !mem_wr;
  endproperty
  a_nowr_absent: assert property (p_nowr_absent) else $error("absent write issued");

  property p_zero_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      ((state == ST_DECODE || state == ST_DONE) && !addr_present) |=> working_word == `WORD_RST;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("absent read not zero");

  property p_parity_halt;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == ST_DECODE && read_parity_bad && parity_halt_in) |=> halted_out && parity_err;
  endproperty
  a_parity_halt: assert property (p_parity_halt) else $error("no parity halt");

  property p_wb_parity;
    @(posedge clk_sys_in) disable iff (rst_in)
      mem_wr |-> !(^readback_word);
  endproperty
  a_wb_parity: assert property (p_wb_parity) else $error("odd parity written");

  property p_wb_addr;
    @(posedge clk_sys_in) disable iff (rst_in)
      mem_wr |-> location_latch == $past(location_latch);
  endproperty
  a_wb_addr: assert property (p_wb_addr) else $error("write-back address moved");

  sequence s_defer_step;
    state == ST_DECODE && read_word[`POS_DEFER] && !(read_parity_bad && parity_halt_in);
  endsequence
  property p_defer;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_defer_step |=> state == ST_DEFER ##1 (state == ST_DECODE || halted_out);
  endproperty
  a_defer: assert property (p_defer) else $error("deferred level skipped");

  property p_verb_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      (state == ST_DEFER) |=> $stable(verb_latch);
  endproperty
  a_verb_hold: assert property (p_verb_hold) else $error("verb changed mid-run");

endmodule : word_cpu_register_and_decode

`default_nettype wire

// ===== testbench/core_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "word_cpu_defines.svh"
// ====================
// Core memory of 16K words that answers only at or below the installed limit
module core_memory_model
  import word_cpu_pkg::*;
(
  input  wire logic                   clk_sys_in,  // Clock
  input  wire logic [1:0]             mem_size_in, // Installed size
  input  wire word_cpu_pkg::mem_req_t req_in,      // Processor request
  input  wire logic                   bad_par_in,  // Flip parity on reads
  output logic [`MEM_W-1:0]           rdata_out,   // Read word
  output logic [15:0]                 access_out,  // Requests seen
  output logic [15:0]                 stray_out    // Writes to absent words
);
  logic [`MEM_W-1:0] mem [0:16383];
  logic              flip = 1'b0;
  logic              present;

  initial begin
    foreach (mem[i]) mem[i] = '0;
    access_out = 16'h0000;
    stray_out = 16'h0000;
  end
  assign present = {2'h0, req_in.addr} < (16'h0800 << mem_size_in);
  // Absent words and idle cycles float, so show a pattern that toggles
  always_comb begin
    if (req_in.rd && present)
      rdata_out = mem[req_in.addr] ^ {bad_par_in, 24'h000000};
    else
      rdata_out = {`MEM_W{flip}} ^ 25'h0aaaaaa;
  end
  always @(posedge clk_sys_in) begin
    flip <= ~flip;
    if (req_in.rd || req_in.wr)
      access_out <= access_out + 16'h0001;
    if (req_in.wr && present)
      mem[req_in.addr] <= req_in.wdata;
    if (req_in.wr && !present)
      stray_out <= stray_out + 16'h0001;
  end
endmodule : core_memory_model
`default_nettype wire

// ===== testbench/word_cpu_register_and_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "word_cpu_defines.svh"
// ====================
// Bench top
module word_cpu_register_and_decode_tb_top;
  import word_cpu_pkg::*;
  localparam logic [4:0] c_loff  = 5'h01;
  localparam logic [4:0] c_low   = 5'h02;
  localparam logic [4:0] c_sum   = 5'h04;
  localparam logic [4:0] c_redir = 5'h08;
  localparam logic [4:0] c_store = 5'h10;
  logic              clk   = 1'b0;
  logic              rst   = 1'b1;
  logic              start = 1'b0;
  logic [1:0]        size  = 2'h3;
  logic              pwr   = 1'b1;
  logic              phalt = 1'b0;
  logic              store = 1'b0;
  logic              redir = 1'b0;
  logic [13:0]       raddr = 14'h0000;
  logic              lsum  = 1'b0;
  logic              llow  = 1'b0;
  logic              loff  = 1'b0;
  logic [23:0]       sdata = 24'h000000;
  logic              badp  = 1'b0;
  logic [`MEM_W-1:0] rdata;
  mem_req_t          req;
  visible_t          vis;
  logic [23:0]       ww;
  logic [5:0]        verb;
  decode_t           dec;
  logic [13:0]       eff;
  logic              busy;
  logic              bsy   = 1'b0;
  logic              done;
  logic              halted;
  logic              perr;
  logic              pfail;
  logic [15:0]       acc;
  logic [15:0]       stray;
  int                errors      = 0;
  int                comparisons = 0;

  word_cpu_register_and_decode u_dut (
    .clk_sys_in(clk), .rst_in(rst), .start_in(start), .mem_size_in(size),
    .power_ok_in(pwr), .parity_halt_in(phalt), .store_in(store), .redirect_in(redir),
    .redirect_addr_in(raddr), .load_sum_in(lsum), .load_low_in(llow),
    .load_offset_in(loff), .store_data_in(sdata), .mem_rdata_in(rdata),
    .mem_req_out(req), .visible_out(vis), .decode_out(dec), .working_word_out(ww),
    .verb_out(verb), .effective_out(eff), .busy_out(busy), .done_out(done),
    .halted_out(halted), .parity_err_out(perr), .power_fail_out(pfail));

  core_memory_model u_mem (
    .clk_sys_in(clk), .mem_size_in(size), .req_in(req), .bad_par_in(badp),
    .rdata_out(rdata), .access_out(acc), .stray_out(stray));

  initial begin
    forever #5 clk = ~clk;
  end

  // ====================
  // Helpers
  function automatic logic [24:0] mw(input logic [23:0] d);
    return {^d, d};
  endfunction : mw
  function automatic logic [23:0] ins(input logic o, input logic [6:0] c, input logic i,
                                      input logic [13:0] a);
    return {1'b0, o, c, i, a};
  endfunction : ins
  task automatic put(input logic [13:0] a, input logic [23:0] d);
    u_mem.mem[a] = mw(d);
  endtask : put
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] time %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset(input logic [1:0] s);
    @(negedge clk);
    rst = 1'b1;
    size = s;
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  task automatic run(input logic [4:0] ctl, output logic seen);
    seen = 1'b0;
    @(negedge clk);
    {store, redir, lsum, llow, loff} = ctl;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    bsy = busy;
    for (int n = 0; n < 40 && !seen; n++) begin
      @(negedge clk);
      seen = (done === 1'b1);
    end
    // Let the last write-back land in memory
    @(negedge clk);
    {store, redir, lsum, llow, loff} = 5'h00;
  endtask : run
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // ====================
  // Tests
  initial begin
    logic        ok;
    logic [13:0] lim;
    logic [15:0] a0;
    for (int s = 0; s < 4; s++) begin
      lim = 14'((15'h0800 << s) - 15'h0001);
      do_reset(2'(s));
      put(14'h0000, ins(1'b0, 7'h3e, 1'b0, lim));
      put(14'h0001, ins(1'b0, 7'h3e, 1'b0, lim + 14'h0001));
      put(14'h0002, ins(1'b0, 7'h3e, 1'b0, lim + 14'h0001));
      put(lim, 24'h13579b ^ 24'(s));
      run(c_sum, ok);
      check(vis.sum_register, 24'h13579b ^ 24'(s));
      run(c_sum, ok);
      check(vis.sum_register, (s == 3) ? ins(1'b0, 7'h3e, 1'b0, lim) : 24'h0);
      sdata = 24'h5a5a5b;
      run(c_store, ok);
      check(vis.instruction_locator, 14'h0003);
      check(u_mem.mem[0], mw((s == 3) ? sdata : ins(1'b0, 7'h3e, 1'b0, lim)));
      $display("size test %0d finished", s);
    end
    check(stray, 16'h0000);
    do_reset(2'h3);
    check(vis, '0);
    put(14'h0000, ins(1'b0, 7'h3e, 1'b0, 14'h0100) | 24'h800000);
    put(14'h0100, 24'h123456);
    run(c_sum, ok);
    check(ok, 1'b1);
    check(bsy, 1'b1);
    check(vis.sum_register, 24'h123456);
    check(ww, 24'h123456);
    check(verb, 6'h3e);
    check(vis.instruction_locator, 14'h0001);
    check(u_mem.mem[0], mw(ins(1'b0, 7'h3e, 1'b0, 14'h0100) | 24'h800000));
    check(u_mem.mem[14'h0100], mw(24'h123456));
    check(perr, 1'b0);
    put(14'h0001, ins(1'b0, 7'h5a, 1'b0, 14'h0200));
    put(14'h0200, 24'habc006);
    run(c_loff, ok);
    check(vis.offset_word, 24'habc006);
    check(verb, 6'h1a);
    check(dec, {1'b0, 7'h57, 1'b1, 14'h0006, 3'h1, 1'b1});
    put(14'h0002, ins(1'b1, 7'h3e, 1'b0, 14'h3ffe));
    put(14'h0004, 24'h654321);
    run(c_low, ok);
    check(vis.low_extension, 24'h654321);
    check(eff, 14'h0327);
    $display("index test finished");
    put(14'h0003, ins(1'b1, 7'h3e, 1'b1, 14'h0300));
    put(14'h0306, ins(1'b0, 7'h00, 1'b1, 14'h0500));
    put(14'h0500, ins(1'b1, 7'h00, 1'b0, 14'h0600));
    put(14'h0606, 24'h0f0f0f);
    raddr = 14'h3fff;
    run(c_sum | c_redir, ok);
    check(vis.sum_register, 24'h0f0f0f);
    check(vis.instruction_locator, 14'h3fff);
    put(14'h3fff, ins(1'b0, 7'h3e, 1'b0, 14'h0004));
    run(c_sum, ok);
    check(vis.sum_register, 24'h654321);
    check(vis.instruction_locator, 14'h0000);
    $display("deferred and wrap test finished");
    badp = 1'b1;
    run(c_sum, ok);
    check(perr, 1'b1);
    check(halted, 1'b0);
    phalt = 1'b1;
    run(c_sum, ok);
    check(halted, 1'b1);
    badp = 1'b0;
    phalt = 1'b0;
    $display("parity test finished");
    do_reset(2'h3);
    pwr = 1'b0;
    a0 = acc;
    run(c_sum, ok);
    check(ok, 1'b0);
    check({pfail, halted}, 2'h3);
    check(acc, a0);
    pwr = 1'b1;
    run(c_sum, ok);
    check(vis.instruction_locator, 14'h0000);
    check({bsy, halted}, 2'h1);
    $display("power test finished");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule : word_cpu_register_and_decode_tb_top
`default_nettype wire
